/* logic/pmlc_top.sv */
// pmlc_top: loads power-management and link-control preset words into
// per-port configuration fields and serves configuration reads afterwards.
// assumes an APB3 master on the core clock and a same-clock config requester.
// the bus waits out a load pass, so the status busy bit reads 0 over apb.
// config reads show the words of the last pass, not the live store.
//
// How it works
// - word bit 0 becomes no-soft-reset bit 3 of offset 44h, ports 2 and 3.
// - word bits 3:1 become auxiliary current bits 24:22 of offset 40h.
// - bit 25 of offset 40h always reads 1, D1 supported.
// - bit 26 of offset 40h always reads 1, D2 supported.
// - word bits 7:6 become PME support bits 29:28 of offset 40h.
// - word bits 15:8 become read-only data byte 31:24 of offset 44h.
// - power words default low byte FFh, data byte 00h.
// - words 50h and 52h map the same way for ports 0 and 1.
module pmlc_top (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // apb slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [pmlc_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [pmlc_pkg::DATA_W-1:0]    pwdata,
    output logic      [pmlc_pkg::DATA_W-1:0]    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // configuration read port
    input  wire logic                           cfg_req,
    input  wire logic [pmlc_pkg::PORT_W-1:0]    cfg_port,
    input  wire logic [pmlc_pkg::ADDR_W-1:0]    cfg_offset,
    output logic                                cfg_ack,
    output logic      [pmlc_pkg::DATA_W-1:0]    cfg_rdata,
    // status
    output logic                                loaded
);
    import pmlc_pkg::*;

    // one-hot loader states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ISSUE = 3'b010,
        ST_CAPT  = 3'b100
    } pmlc_state_t;

    // loader state and captured words
    pmlc_state_t                        state;
    pmlc_state_t                        next_state;
    logic [SLOT_W-1:0]                  slot;
    logic [SLOT_W-1:0]                  next_slot;
    logic                               busy_q;
    logic [NUM_PORTS-1:0][WORD_W-1:0]   pm_word;
    logic [NUM_PORTS-1:0][WORD_W-1:0]   link_word;
    logic [WORD_W-1:0]                  mem_rdata;
    logic [DATA_W-1:0]                  cap_word;
    logic [DATA_W-1:0]                  pmd_word;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    // handshake terms
    wire               busy       = (state != ST_IDLE);
    wire               capt       = (state == ST_CAPT);
    wire               apb_access = psel & penable;
    wire               apb_go     = apb_access & ~pready & ~busy & ~busy_q;
    wire               apb_commit = apb_access & pready;

    // address decode
    wire [7:0]         idx        = paddr[9:2];
    wire [7:0]         idx_off    = idx - IDX_PM_P0;
    wire               word_algn  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    wire               is_preset  = word_algn && (idx >= IDX_PM_P0) && (idx <= IDX_LINK_P3)
                                    && !idx[0];
    wire               is_ctrl    = (paddr == CTRL_ADDR);
    wire               is_stat    = (paddr == STAT_ADDR);
    wire               mapped     = is_preset | is_ctrl | is_stat;

    // store and control strobes
    wire [SLOT_W-1:0]  apb_slot   = idx_off[SLOT_W:1];
    wire [SLOT_W-1:0]  mem_raddr  = busy ? slot : apb_slot;
    wire               mem_we     = apb_commit & pwrite & is_preset;
    wire               start      = apb_commit & pwrite & is_ctrl & pwdata[CTRL_START_BIT];

    // read data selection
    wire [DATA_W-1:0]  stat_word  = DATA_W'({busy, loaded});
    wire [DATA_W-1:0]  apb_rmux   = is_preset ? DATA_W'(mem_rdata) :
                                    is_stat   ? stat_word : '0;

    // apb answer: one wait cycle, then pready for a single cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= apb_go;
            pslverr <= apb_go & ~mapped;
            if (apb_go) begin
                prdata <= apb_rmux;
            end
        end
    end

    // ****************************************************************
    // preset word store
    // ****************************************************************
    pmlc_mem #(
        .W       (WORD_W),
        .DEPTH   (NUM_SLOTS),
        .AW      (SLOT_W),
        .INIT    (PRESET_INIT)
    ) u_mem (
        .clk     (clk),
        .rst_n   (rst_n),
        .we      (mem_we),
        .wr_addr (apb_slot),
        .wr_data (pwdata[WORD_W-1:0]),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    // ****************************************************************
    // loader sequence: reset starts a full pass, start bit repeats it
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_slot  = slot;
        unique case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_ISSUE;
                    next_slot  = SLOT_FIRST;
                end
            end
            ST_ISSUE: begin
                next_state = ST_CAPT;
            end
            ST_CAPT: begin
                if (slot == SLOT_LAST) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_ISSUE;
                    next_slot  = SLOT_W'(slot + 3'h1);
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state, slot and done flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state  <= ST_ISSUE;
            slot   <= SLOT_FIRST;
            busy_q <= 1'b1;
            loaded <= 1'b0;
        end else begin
            state  <= next_state;
            slot   <= next_slot;
            busy_q <= busy;
            if (capt && slot == SLOT_LAST) begin
                loaded <= 1'b1;
            end else if (start) begin                // set wins a tie
                loaded <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // per-port loaded words: slots 0..3 power, 4..7 link control
    // ****************************************************************
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        // capture the word read for this port's slot
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pm_word[p]   <= PM_WORD_RST;
                link_word[p] <= LINK_WORD_RST;
            end else begin
                if (capt && slot == SLOT_W'(p)) begin
                    pm_word[p] <= mem_rdata;
                end
                if (capt && slot == SLOT_W'(p + NUM_PORTS)) begin
                    link_word[p] <= mem_rdata;
                end
            end
        end
    end

    // ****************************************************************
    // configuration space view
    // ****************************************************************
    wire [WORD_W-1:0] sel_pm   = pm_word[cfg_port];
    wire [WORD_W-1:0] sel_link = link_word[cfg_port];

    // assemble offsets 40h and 44h from the power word
    always_comb begin
        cap_word                        = '0;
        cap_word[CFG_AUX_HI:CFG_AUX_LO] = sel_pm[PM_AUX_HI:PM_AUX_LO];
        cap_word[CFG_D1_BIT]            = 1'b1;
        cap_word[CFG_D2_BIT]            = 1'b1;
        cap_word[CFG_PME_HI:CFG_PME_LO] = sel_pm[PM_PME_HI:PM_PME_LO];
        pmd_word                        = '0;
        pmd_word[CFG_NOSOFT]            = sel_pm[PM_NOSOFT_BIT];
        pmd_word[CFG_DATA_HI:CFG_DATA_LO] = sel_pm[PM_DATA_HI:PM_DATA_LO];
    end

    // config read data select
    wire [DATA_W-1:0] cfg_mux = (cfg_offset == CFG_PM_CAP)  ? cap_word :
                                (cfg_offset == CFG_PM_DATA) ? pmd_word :
                                (cfg_offset == CFG_LINK)    ? DATA_W'(sel_link) : '0;

    // take a request only once loaded
    wire              cfg_go  = cfg_req & loaded & ~cfg_ack;

    // answer config reads only once loading is complete
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= '0;
        end else begin
            cfg_ack <= cfg_go;
            if (cfg_go) begin
                cfg_rdata <= cfg_mux;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    // helper for the default check
    logic wrote_any;

    // remembers any software write to the preset store
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrote_any <= 1'b0;
        end else if (mem_we) begin
            wrote_any <= 1'b1;
        end
    end

    // core clock, quiet in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // 44h bit 3 follows word bit 0
    AST_NOSOFT: assert property (cfg_ack && $past(cfg_offset) == CFG_PM_DATA
        |-> cfg_rdata[CFG_NOSOFT] == $past(sel_pm[PM_NOSOFT_BIT]))
        else $error("no-soft-reset bit wrong");

    // aux current field
    AST_AUX: assert property (cfg_ack && $past(cfg_offset) == CFG_PM_CAP
        |-> cfg_rdata[CFG_AUX_HI:CFG_AUX_LO] == $past(sel_pm[PM_AUX_HI:PM_AUX_LO]))
        else $error("aux current field wrong");

    // both low-power states shown
    AST_D1D2: assert property (cfg_ack && $past(cfg_offset) == CFG_PM_CAP
        |-> cfg_rdata[CFG_D1_BIT] && cfg_rdata[CFG_D2_BIT])
        else $error("d1 or d2 support bit not one");

    // d1 bit 1 with word bit 4 clear
    AST_D1_FIXED: assert property (cfg_ack && $past(cfg_offset) == CFG_PM_CAP
        && $past(sel_pm[PM_AUX_HI+1]) == 1'b0 |-> cfg_rdata[CFG_D1_BIT])
        else $error("d1 bit follows the word");

    // d2 bit 1 with word bit 5 clear
    AST_D2_FIXED: assert property (cfg_ack && $past(cfg_offset) == CFG_PM_CAP
        && $past(sel_pm[PM_AUX_HI+2]) == 1'b0 |-> cfg_rdata[CFG_D2_BIT])
        else $error("d2 bit follows the word");

    // pme support field
    AST_PME: assert property (cfg_ack && $past(cfg_offset) == CFG_PM_CAP
        |-> cfg_rdata[CFG_PME_HI:CFG_PME_LO] == $past(sel_pm[PM_PME_HI:PM_PME_LO]))
        else $error("pme support field wrong");

    // read-only data byte
    AST_DATA: assert property (cfg_ack && $past(cfg_offset) == CFG_PM_DATA
        |-> cfg_rdata[CFG_DATA_HI:CFG_DATA_LO] == $past(sel_pm[PM_DATA_HI:PM_DATA_LO]))
        else $error("data byte wrong");

    // untouched store keeps power defaults for ports 2 and 3
    AST_DEFAULT: assert property (loaded && !wrote_any
        |-> pm_word[2] == PM_WORD_RST && pm_word[3] == PM_WORD_RST)
        else $error("power word default wrong");

    // link word, zero extended
    AST_LINK: assert property (cfg_ack && $past(cfg_offset) == CFG_LINK
        |-> cfg_rdata == DATA_W'($past(sel_link)))
        else $error("link control word wrong");

    // last slot fills port 3 link word
    AST_LINK_P3: assert property (capt && slot == SLOT_LAST
        |=> link_word[NUM_PORTS-1] == $past(mem_rdata))
        else $error("port 3 link word not captured");

    // port 0 uses the same path
    AST_PORT0: assert property (capt && slot == SLOT_FIRST
        |=> pm_word[0] == $past(mem_rdata))
        else $error("port 0 power word not captured");

    // port 3 power word from its slot
    AST_PM_P3: assert property (capt && slot == SLOT_W'(NUM_PORTS-1)
        |=> pm_word[NUM_PORTS-1] == $past(mem_rdata))
        else $error("port 3 power word not captured");

    // no answer before the pass ends
    AST_NO_EARLY: assert property (cfg_ack |-> $past(loaded))
        else $error("config read answered before load");

    // two cycles per slot
    AST_LOAD_TIME: assert property (start |-> ##[16:17] loaded)
        else $error("load pass did not finish in time");

    // loaded falls only on a start
    AST_LOADED_HOLDS: assert property (loaded && !start |=> loaded)
        else $error("loaded dropped without a start");

    // no bus answer mid-pass
    AST_STALL: assert property (busy |=> !pready)
        else $error("bus answered during a load pass");

    // one answer per request
    AST_ACK_PULSE: assert property (cfg_ack |=> !cfg_ack)
        else $error("config answer longer than one cycle");

    // main scenarios
    COV_APB_WRITE: cover property (apb_commit && pwrite && is_preset);
    COV_RELOAD:    cover property (start ##[1:20] loaded);
    COV_CFG_CAP:   cover property (cfg_ack && $past(cfg_offset) == CFG_PM_CAP);
    COV_SLVERR:    cover property (pready && pslverr);
    COV_STALL:     cover property (apb_access && busy);

endmodule // pmlc_top

/* pkg/pmlc_pkg.sv */
// pmlc_pkg: constants shared by the power-management / link-control loader.
// assumes one 50 MHz core clock and an APB3 slave port with 12-bit byte addresses.
package pmlc_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int NUM_PORTS = 4;
    localparam int NUM_SLOTS = 8;
    localparam int SLOT_W    = 3;
    localparam int WORD_W    = 16;
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int PORT_W    = 2;

    // ****************************************************************
    // loader word indices as printed (byte address is four times these)
    // ****************************************************************
    localparam logic [7:0] IDX_PM_P0   = 8'h50;
    localparam logic [7:0] IDX_PM_P1   = 8'h52;
    localparam logic [7:0] IDX_PM_P2   = 8'h54;
    localparam logic [7:0] IDX_PM_P3   = 8'h56;
    localparam logic [7:0] IDX_LINK_P0 = 8'h58;
    localparam logic [7:0] IDX_LINK_P1 = 8'h5A;
    localparam logic [7:0] IDX_LINK_P2 = 8'h5C;
    localparam logic [7:0] IDX_LINK_P3 = 8'h5E;

    // ****************************************************************
    // own control and status registers (byte addresses)
    // ****************************************************************
    localparam logic [ADDR_W-1:0] CTRL_ADDR      = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_ADDR      = 12'h004;
    localparam int                CTRL_START_BIT = 0;
    localparam int                STAT_DONE_BIT  = 0;
    localparam int                STAT_BUSY_BIT  = 1;

    // ****************************************************************
    // slot numbers inside the preset memory
    // ****************************************************************
    localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h0;
    localparam logic [SLOT_W-1:0] SLOT_LAST  = 3'h7;

    // ****************************************************************
    // fields of the power-management preset word
    // ****************************************************************
    localparam int PM_NOSOFT_BIT = 0;
    localparam int PM_AUX_LO     = 1;
    localparam int PM_AUX_HI     = 3;
    localparam int PM_PME_LO     = 6;
    localparam int PM_PME_HI     = 7;
    localparam int PM_DATA_LO    = 8;
    localparam int PM_DATA_HI    = 15;

    // ****************************************************************
    // configuration space offsets and fields
    // ****************************************************************
    localparam logic [ADDR_W-1:0] CFG_PM_CAP   = 12'h040;
    localparam logic [ADDR_W-1:0] CFG_PM_DATA  = 12'h044;
    localparam logic [ADDR_W-1:0] CFG_LINK     = 12'h340;
    localparam int                CFG_AUX_LO   = 22;
    localparam int                CFG_AUX_HI   = 24;
    localparam int                CFG_D1_BIT   = 25;
    localparam int                CFG_D2_BIT   = 26;
    localparam int                CFG_PME_LO   = 28;
    localparam int                CFG_PME_HI   = 29;
    localparam int                CFG_NOSOFT   = 3;
    localparam int                CFG_DATA_LO  = 24;
    localparam int                CFG_DATA_HI  = 31;
    localparam int                CFG_LINK_HI  = 15;

    // ****************************************************************
    // defaults
    // ****************************************************************
    localparam logic [WORD_W-1:0]           PM_WORD_RST   = 16'h00FF;
    localparam logic [WORD_W-1:0]           LINK_WORD_RST = 16'h0000;
    localparam logic [NUM_SLOTS*WORD_W-1:0] PRESET_INIT   =
        {{NUM_PORTS{LINK_WORD_RST}}, {NUM_PORTS{PM_WORD_RST}}};

endpackage

/* logic/pmlc_mem.sv */
// pmlc_mem: small preset word store, one write port, one registered read port.
// assumes a single clock; contents return to INIT on reset.
module pmlc_mem #(
    parameter int                     W     = 16,
    parameter int                     DEPTH = 8,
    parameter int                     AW    = 3,
    parameter logic [DEPTH*W-1:0]     INIT  = '0
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);

    logic [DEPTH-1:0][W-1:0] mem;

    // ****************************************************************
    // storage, one word per entry
    // ****************************************************************
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        // each entry resets to its own default
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem[i] <= INIT[i*W +: W];
            end else if (we && wr_addr == AW'(i)) begin
                mem[i] <= wr_data;
            end
        end
    end

    // registered read, one cycle after the address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // pmlc_mem

/* verification/pmlc_cfg_host.sv */
// pmlc_cfg_host: configuration requester model facing the loader's read port.
// assumes the loader's clock; go is a one-cycle pulse given only while idle.
module pmlc_cfg_host (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // bench control
    input  wire logic                        go,
    input  wire logic [1:0]                  tgt_port,
    input  wire logic [pmlc_pkg::ADDR_W-1:0] tgt_offset,
    input  wire logic [1:0]                  delay,
    output logic                             done,
    output logic      [pmlc_pkg::DATA_W-1:0] data,
    // loader read port
    output logic                             cfg_req,
    output logic      [1:0]                  cfg_port,
    output logic      [pmlc_pkg::ADDR_W-1:0] cfg_offset,
    input  wire logic                        cfg_ack,
    input  wire logic [pmlc_pkg::DATA_W-1:0] cfg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import pmlc_pkg::*;
    logic              busy;
    logic [1:0]        wait_cnt;
    logic [1:0]        hold_port;
    logic [ADDR_W-1:0] hold_off;

    // request held until ack, then released with scrambled lines
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy       <= 1'h0;
            done       <= 1'h0;
            cfg_req    <= 1'h0;
            cfg_port   <= 2'h0;
            cfg_offset <= 12'h0;
        end else begin
            done <= 1'h0;
            if (go && !busy) begin
                busy      <= 1'h1;
                wait_cnt  <= delay;
                hold_port <= tgt_port;
                hold_off  <= tgt_offset;
            end else if (busy && !cfg_req) begin
                if (wait_cnt == 2'h0) begin
                    cfg_req    <= 1'h1;
                    cfg_port   <= hold_port;
                    cfg_offset <= hold_off;
                end else begin
                    wait_cnt <= wait_cnt - 2'h1;
                end
            end else if (cfg_req && cfg_ack) begin
                data       <= cfg_rdata;
                done       <= 1'h1;
                busy       <= 1'h0;
                cfg_req    <= 1'h0;  // dropped right after the answer
                cfg_port   <= ~cfg_port;
                cfg_offset <= ~cfg_offset;
            end
        end
    end
endmodule // pmlc_cfg_host

/* verification/tb.sv */
// tb: self-checking bench for the preset loader, APB master plus config requester.
// assumes pmlc_pkg, pmlc_top and pmlc_cfg_host are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pmlc_pkg::*;
    // ****************************************************************
    // signals and bench state
    // ****************************************************************
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, loaded, cfg_req, cfg_ack;
    logic go, done;
    logic [ADDR_W-1:0] paddr, cfg_offset, to;
    logic [DATA_W-1:0] pwdata, prdata, cfg_rdata, rd, hdata;
    logic [1:0]        cfg_port, tp, dly;
    logic              err;
    logic [31:0]       rnd = 32'h0001_498B;  // 84363
    logic [WORD_W-1:0] pm [4];
    logic [WORD_W-1:0] lk [4];
    logic [WORD_W-1:0] nw [8];
    logic [ADDR_W-1:0] offs [4] = '{CFG_PM_CAP, CFG_PM_DATA, CFG_LINK, 12'h048};
    int num_errors = 0;
    int checked = 0;

    pmlc_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_req(cfg_req), .cfg_port(cfg_port),
        .cfg_offset(cfg_offset), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .loaded(loaded));
    pmlc_cfg_host host (.clk(clk), .rst_n(rst_n), .go(go), .tgt_port(tp),
        .tgt_offset(to), .delay(dly), .done(done), .data(hdata), .cfg_req(cfg_req),
        .cfg_port(cfg_port), .cfg_offset(cfg_offset), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata));

    // 50 MHz clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // byte address of preset slot i: word index times four
    function automatic logic [ADDR_W-1:0] sa(input int i);
        return ADDR_W'({IDX_PM_P0, 2'h0}) + ADDR_W'(8 * i);
    endfunction
    // config view expected from the captured words
    function automatic logic [DATA_W-1:0] exp_cfg(input logic [1:0] p,
                                                  input logic [ADDR_W-1:0] o);
        logic [WORD_W-1:0] w;
        w = pm[p];
        if (o == CFG_PM_CAP) return {2'h0, w[7:6], 1'h0, 2'h3, w[3:1], 22'h0};
        if (o == CFG_PM_DATA) return {w[15:8], 20'h0, w[0], 3'h0};
        if (o == CFG_LINK) return {16'h0, lk[p]};
        return 32'h0;
    endfunction
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] wd);
        int n;
        @(posedge clk);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        penable <= 1'h0;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 200);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (n >= 200) num_errors++;
    endtask
    // one config read through the requester model
    task automatic cfg(input logic [1:0] p, input logic [ADDR_W-1:0] o);
        int n;
        @(posedge clk);
        go  <= 1'h1;
        tp  <= p;
        to  <= o;
        dly <= rnd[1:0];
        rnd = lfsr(rnd);
        @(posedge clk);
        go <= 1'h0;
        n = 0;
        while (done !== 1'h1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) num_errors++;
    endtask
    task automatic sweep();
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int k = 0; k < 4; k++) begin
                cfg(2'(p), offs[k]);
                check(hdata, exp_cfg(2'(p), offs[k]));
            end
        end
    endtask
    task automatic give_verdict();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rst_n, psel, penable, pwrite, go} = 5'h0;
        {paddr, to, pwdata, tp, dly} = '0;
        for (int i = 0; i < 4; i++) begin
            pm[i] = PM_WORD_RST;
            lk[i] = LINK_WORD_RST;
        end
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        // request raised before the first pass ends
        cfg(2'h2, CFG_PM_DATA);
        check({31'h0, loaded}, 32'h1);
        check(hdata, exp_cfg(2'h2, CFG_PM_DATA));
        for (int i = 0; i < NUM_SLOTS; i++) begin
            apb(1'h0, sa(i), 32'h0);
            check(rd, (i < 4) ? 32'h0000_00FF : 32'h0);
        end
        sweep();
        // unmapped holes, control and status registers
        apb(1'h1, 12'h144, 32'h0000_FFFF);
        check({31'h0, err}, 32'h1);
        apb(1'h0, 12'h100, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000);
        apb(1'h0, sa(0), 32'h0);
        check(rd, 32'h0000_00FF);
        apb(1'h1, STAT_ADDR, 32'h0);
        apb(1'h0, STAT_ADDR, 32'h0);
        check(rd, 32'h1);
        apb(1'h0, CTRL_ADDR, 32'h0);
        check(rd, 32'h0);
        // rounds of new words: all ones, all zeros, then random
        for (int r = 0; r < 6; r++) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                nw[i] = (r == 0) ? 16'hFFFF : (r == 1) ? 16'h0000 : rnd[15:0];
                apb(1'h1, sa(i), {rnd[31:16], nw[i]});
                rnd = lfsr(rnd);
            end
            for (int i = 0; i < NUM_SLOTS; i++) begin
                apb(1'h0, sa(i), 32'h0);
                check(rd, {16'h0, nw[i]});
            end
            cfg(2'(r % 4), CFG_LINK);
            check(hdata, exp_cfg(2'(r % 4), CFG_LINK));
            apb(1'h1, CTRL_ADDR, 32'h1);
            repeat (2) @(posedge clk);
            check({31'h0, loaded}, 32'h0);
            apb(1'h0, STAT_ADDR, 32'h0); // waits out the pass
            check(rd, 32'h1);
            for (int i = 0; i < 4; i++) begin
                pm[i] = nw[i];
                lk[i] = nw[i + 4];
            end
            sweep();
        end
        give_verdict();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule // tb
